// file: hbad_top.sv
// Purpose: host port address decode with a 64-location register space
// Assumes: host pins synchronous to ref_clk; straps and selects static
// Notes: software watches and steers the decode over AXI4-Lite
//
// Overview of operation
// RQ1: board selects bus style with two select pins; both-high needs compat lead high
// RQ2: both-high multiplexed style reaches only 00H-1FH, three straps used
// RQ3: high/low multiplexed style spans 00H-3FH; compat lead gates 25H-3FH
// RQ4: separate buses reach 00H-3FH with lead high, only up to 24H when low
// RQ5: two-strap styles: low six bits index, top two must match straps
// RQ6: both-high style: low five bits index, top three must match straps
// RQ7: multiplexed styles ignore dedicated address pins, take address from shared lines
// RQ8: separate-bus host presents address on dedicated pins, bit 7 most significant
// RQ9: strap mismatch or disabled index means no drive and no register change
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module hbad_top #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // style and placement pins
  input wire logic bus_type_sel_hi,
  input wire logic bus_type_sel_lo,
  input wire logic compat_mode_lead,
  input wire logic segment_strap_top,
  input wire logic segment_strap_mid,
  input wire logic segment_strap_low,
  // host access pins
  input wire logic [7:0] dedicated_addr_in,
  input wire logic [7:0] shared_addr_data_in,
  output logic [7:0] shared_addr_data_out,
  output logic shared_addr_data_oe_n,
  input wire logic host_sel_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_ale,
  // register bus
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready
);

  // ==========================================================
  // style decode
  hbad_pkg::hbad_mode_e mode;
  logic illegal;
  logic three_straps;
  logic [5:0] limit;
  logic mux_bus;

  hbad_mode_dec u_mode (
    .sel_hi(bus_type_sel_hi),
    .sel_lo(bus_type_sel_lo),
    .compat(compat_mode_lead),
    .mode(mode),
    .illegal(illegal),
    .three_straps(three_straps),
    .limit(limit)
  );

  assign mux_bus = (mode == hbad_pkg::HBAD_MUX3) || (mode == hbad_pkg::HBAD_MUX2);

  // ==========================================================
  // host cycle detection
  logic acc_level, acc_is_rd, acc_start, acc_end;
  logic acc_q, acc_d;
  logic [7:0] addr_lat_q, addr_lat_d;

  // read/write-line style strobes on select alone; others need rd or wr low
  always_comb begin
    if (mode == hbad_pkg::HBAD_RDWR) begin
      acc_level = ~host_sel_n;
      acc_is_rd = host_rd_n;
    end else begin
      acc_level = ~host_sel_n & (~host_rd_n | ~host_wr_n);
      acc_is_rd = ~host_rd_n;
    end
  end

  assign acc_start = acc_level & ~acc_q;
  assign acc_end = acc_q & ~acc_level;

  // address latch from the shared lines while ale is high
  always_comb begin
    acc_d = acc_level;
    addr_lat_d = addr_lat_q;
    if (mux_bus && host_ale) begin
      addr_lat_d = shared_addr_data_in; // [RQ7]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= 1'b0;
      addr_lat_q <= 8'h00;
    end else if (clk_en) begin
      acc_q <= acc_d;
      addr_lat_q <= addr_lat_d;
    end
  end

  // ==========================================================
  // address split and match
  logic [7:0] acc_addr;
  logic [5:0] acc_idx;
  logic strap_ok, acc_hit;
  logic ctrl_en_q, ctrl_en_d;

  always_comb begin
    // dedicated pins are never looked at on a multiplexed style
    acc_addr = mux_bus ? addr_lat_q : dedicated_addr_in; // [RQ7] [RQ8]
    if (three_straps) begin
      acc_idx = 6'(acc_addr[hbad_pkg::HBAD_IDX3_W-1:0]); // [RQ6]
      strap_ok = acc_addr[7:hbad_pkg::HBAD_IDX3_W] ==
                 {segment_strap_top, segment_strap_mid, segment_strap_low}; // [RQ6]
    end else begin
      acc_idx = acc_addr[hbad_pkg::HBAD_IDX_W-1:0]; // [RQ5]
      strap_ok = acc_addr[7:hbad_pkg::HBAD_IDX_W] == {segment_strap_top, segment_strap_mid}; // [RQ5]
    end
    acc_hit = strap_ok & (acc_idx <= limit) & ~illegal & ctrl_en_q; // [RQ2] [RQ3] [RQ4] [RQ9]
  end

  // ==========================================================
  // host access state
  logic hit_q, hit_d, rd_q, rd_d;
  logic [5:0] idx_q, idx_d;
  logic [7:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [7:0] reg_mem_q [hbad_pkg::HBAD_SPACE];
  logic mem_we;

  // decode is frozen at the start of each cycle so mid-cycle pin noise cannot move it
  always_comb begin
    hit_d = hit_q;
    rd_d = rd_q;
    idx_d = idx_q;
    rdata_d = rdata_q;
    wdata_d = wdata_q;
    if (acc_start) begin
      hit_d = acc_hit;
      rd_d = acc_is_rd;
      idx_d = acc_idx;
      rdata_d = reg_mem_q[acc_idx];
    end
    if (acc_level) begin
      wdata_d = shared_addr_data_in;
    end
  end

  // write commits at the trailing edge with the last sampled data
  assign mem_we = acc_end & hit_q & ~rd_q; // [RQ9]
  assign shared_addr_data_out = rdata_q;
  assign shared_addr_data_oe_n = ~(acc_level & acc_q & hit_q & rd_q); // [RQ9]

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hit_q <= 1'b0;
      rd_q <= 1'b0;
      idx_q <= 6'h00;
      rdata_q <= 8'h00;
      wdata_q <= 8'h00;
    end else if (clk_en) begin
      hit_q <= hit_d;
      rd_q <= rd_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
      wdata_q <= wdata_d;
    end
  end

  // register space; written in place rather than through a full next copy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < hbad_pkg::HBAD_SPACE; i++) begin
        reg_mem_q[i] <= 8'h00;
      end
    end else if (clk_en && mem_we) begin
      reg_mem_q[idx_q] <= wdata_q;
    end
  end

  // ==========================================================
  // software registers
  hbad_reg_if #(.ADDR_W(ADDR_W)) rif ();
  logic cnt_clr;
  logic [5:0] win_addr_q, win_addr_d;
  logic [15:0] hit_cnt_q, hit_cnt_d, miss_cnt_q, miss_cnt_d, hit_base, miss_base;

  hbad_axil_slv #(.ADDR_W(ADDR_W)) u_slv (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .rif(rif)
  );

  // write decode; read-only words accept and drop the data
  always_comb begin
    ctrl_en_d = ctrl_en_q;
    win_addr_d = win_addr_q;
    cnt_clr = 1'b0;
    rif.wr_ok = 1'b1;
    case (rif.waddr[7:0])
      hbad_pkg::HBAD_OFF_CTRL: begin
        if (rif.wr_en && rif.wstrb[0]) begin
          ctrl_en_d = rif.wdata[hbad_pkg::HBAD_CTRL_EN_BIT];
          cnt_clr = rif.wdata[hbad_pkg::HBAD_CTRL_CLR_BIT];
        end
      end
      hbad_pkg::HBAD_OFF_WIN_ADDR: begin
        if (rif.wr_en && rif.wstrb[0]) begin
          win_addr_d = rif.wdata[5:0];
        end
      end
      hbad_pkg::HBAD_OFF_STATUS, hbad_pkg::HBAD_OFF_HIT_CNT,
      hbad_pkg::HBAD_OFF_MISS_CNT, hbad_pkg::HBAD_OFF_WIN_DATA: begin
        rif.wr_ok = 1'b1;
      end
      default: rif.wr_ok = 1'b0;
    endcase
  end

  // counters saturate; a count landing with a clear survives as one
  always_comb begin
    hit_base = cnt_clr ? 16'h0000 : hit_cnt_q;
    miss_base = cnt_clr ? 16'h0000 : miss_cnt_q;
    hit_cnt_d = hit_base;
    miss_cnt_d = miss_base;
    if (acc_start && acc_hit && hit_base != hbad_pkg::HBAD_CNT_MAX) begin
      hit_cnt_d = hit_base + 16'h0001;
    end
    if (acc_start && !acc_hit && miss_base != hbad_pkg::HBAD_CNT_MAX) begin
      miss_cnt_d = miss_base + 16'h0001; // [RQ9]
    end
  end

  // read decode
  always_comb begin
    rif.rd_data = 32'h0;
    rif.rd_ok = 1'b1;
    case (rif.raddr[7:0])
      hbad_pkg::HBAD_OFF_CTRL: rif.rd_data[hbad_pkg::HBAD_CTRL_EN_BIT] = ctrl_en_q;
      hbad_pkg::HBAD_OFF_STATUS: begin
        rif.rd_data[1:0] = mode;
        rif.rd_data[hbad_pkg::HBAD_ST_ILL_BIT] = illegal;
        rif.rd_data[hbad_pkg::HBAD_ST_COMPAT_BIT] = compat_mode_lead;
        rif.rd_data[hbad_pkg::HBAD_ST_HIT_BIT] = hit_q;
        rif.rd_data[hbad_pkg::HBAD_ST_RD_BIT] = rd_q;
        rif.rd_data[hbad_pkg::HBAD_ST_IDX_LSB +: 6] = idx_q;
      end
      hbad_pkg::HBAD_OFF_HIT_CNT: rif.rd_data[15:0] = hit_cnt_q;
      hbad_pkg::HBAD_OFF_MISS_CNT: rif.rd_data[15:0] = miss_cnt_q;
      hbad_pkg::HBAD_OFF_WIN_ADDR: rif.rd_data[5:0] = win_addr_q;
      hbad_pkg::HBAD_OFF_WIN_DATA: rif.rd_data[7:0] = reg_mem_q[win_addr_q];
      default: rif.rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_en_q <= hbad_pkg::HBAD_CTRL_EN_RST;
      win_addr_q <= 6'h00;
      hit_cnt_q <= 16'h0000;
      miss_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      ctrl_en_q <= ctrl_en_d;
      win_addr_q <= win_addr_d;
      hit_cnt_q <= hit_cnt_d;
      miss_cnt_q <= miss_cnt_d;
    end
  end

  // ==========================================================
  // checks on the decode
  a_mux3_lead_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
    (clk_en && acc_start && mode == hbad_pkg::HBAD_MUX3 && !compat_mode_lead) |=> !hit_q)
    else $error("both-high style answered with compat lead low");

  a_mux3_idx_bound: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
    (clk_en && acc_start && mode == hbad_pkg::HBAD_MUX3) |=> idx_q == {1'b0, $past(acc_addr[4:0])})
    else $error("both-high style index above 1f");

  a_mux2_upper_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
    (clk_en && acc_start && mode == hbad_pkg::HBAD_MUX2 && acc_idx > hbad_pkg::HBAD_LIM_COMPAT)
    |=> hit_q == $past(compat_mode_lead && strap_ok && ctrl_en_q))
    else $error("upper registers not gated by compat lead");

  a_sep_compat_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
    (clk_en && acc_start && !mux_bus && !compat_mode_lead && dedicated_addr_in[5:0] > 6'h24)
    |=> !hit_q)
    else $error("separate bus reached above 24 with lead low");

  a_sep_full_hit: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4] [RQ5]
    (clk_en && acc_start && !mux_bus && compat_mode_lead && ctrl_en_q &&
     dedicated_addr_in[7:6] == {segment_strap_top, segment_strap_mid})
    |=> hit_q && idx_q == $past(dedicated_addr_in[5:0]))
    else $error("separate bus missed a matching access");

  a_two_strap_match: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
    (clk_en && acc_start && !three_straps && acc_addr[7:6] != {segment_strap_top, segment_strap_mid})
    |=> !hit_q ##1 shared_addr_data_oe_n)
    else $error("two-strap mismatch still answered");

  a_three_strap_match: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
    (clk_en && acc_start && three_straps &&
     acc_addr[7:5] != {segment_strap_top, segment_strap_mid, segment_strap_low}) |=> !hit_q)
    else $error("three-strap mismatch still answered");

  a_mux_addr_src: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
    (clk_en && acc_start && mux_bus) |=> idx_q[4:0] == $past(addr_lat_q[4:0]))
    else $error("multiplexed index not from latched address");

  a_miss_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ9]
    (!hit_q || !rd_q) |-> shared_addr_data_oe_n)
    else $error("data lines driven without a read hit");

  a_miss_counted: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ9]
    (clk_en && acc_start && !acc_hit && !cnt_clr && miss_cnt_q != hbad_pkg::HBAD_CNT_MAX)
    |=> miss_cnt_q == 16'($past(miss_cnt_q) + 16'h0001) && !hit_q)
    else $error("refused access not counted as a miss");

endmodule

// file: hbad_pkg.sv
// Purpose: shared constants and types for the host bus address decode block
// Assumes: 8-bit host port, 32-bit register bus, 64 host registers
// Notes: register bus offsets are byte addresses
package hbad_pkg;

  // ==========================================================
  // bus styles chosen by the two interface-type select pins
  typedef enum logic [1:0] {HBAD_MUX3, HBAD_MUX2, HBAD_STROBE, HBAD_RDWR} hbad_mode_e;

  // ==========================================================
  // host address split and reachable ranges
  localparam int HBAD_IDX_W = 6;             // index width with two straps
  localparam int HBAD_IDX3_W = 5;            // index width with three straps
  localparam int HBAD_SPACE = 64;            // host register locations
  localparam logic [5:0] HBAD_LIM_MUX3 = 6'h1f;
  localparam logic [5:0] HBAD_LIM_FULL = 6'h3f;
  localparam logic [5:0] HBAD_LIM_COMPAT = 6'h24;

  // ==========================================================
  // register bus map
  localparam logic [7:0] HBAD_OFF_CTRL = 8'h00;
  localparam logic [7:0] HBAD_OFF_STATUS = 8'h04;
  localparam logic [7:0] HBAD_OFF_HIT_CNT = 8'h08;
  localparam logic [7:0] HBAD_OFF_MISS_CNT = 8'h0c;
  localparam logic [7:0] HBAD_OFF_WIN_ADDR = 8'h10;
  localparam logic [7:0] HBAD_OFF_WIN_DATA = 8'h14;
  localparam int HBAD_CTRL_EN_BIT = 0;
  localparam int HBAD_CTRL_CLR_BIT = 1;
  localparam logic HBAD_CTRL_EN_RST = 1'b1;
  localparam int HBAD_ST_ILL_BIT = 2;
  localparam int HBAD_ST_COMPAT_BIT = 3;
  localparam int HBAD_ST_HIT_BIT = 4;
  localparam int HBAD_ST_RD_BIT = 5;
  localparam int HBAD_ST_IDX_LSB = 8;
  localparam int HBAD_CNT_W = 16;
  localparam logic [15:0] HBAD_CNT_MAX = 16'hffff;
  localparam logic [1:0] HBAD_RESP_OKAY = 2'h0;
  localparam logic [1:0] HBAD_RESP_SLVERR = 2'h2;

endpackage

// file: hbad_reg_if.sv
// Purpose: carries register accesses from the bus slave to the register file
// Assumes: one write strobe and a read address with no strobe, decoded combinationally by the file
// Notes: wr_en stands until the slave has recorded the response
`timescale 1ns/1ps
interface hbad_reg_if #(
  parameter int ADDR_W = 8
);
  logic wr_en;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_ok;
  logic [ADDR_W-1:0] raddr;
  logic [31:0] rd_data;
  logic rd_ok;

  modport bus (output wr_en, waddr, wdata, wstrb, raddr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, waddr, wdata, wstrb, raddr, output wr_ok, rd_data, rd_ok);
endinterface

// file: hbad_mode_dec.sv
// Purpose: turns the select pins and compatibility lead into a bus style
// Assumes: pins are static during operation
// Notes: purely combinational
`timescale 1ns/1ps
module hbad_mode_dec (
  // select pins
  input wire logic sel_hi,
  input wire logic sel_lo,
  input wire logic compat,
  // decoded style
  output hbad_pkg::hbad_mode_e mode,
  output logic illegal,
  output logic three_straps,
  output logic [5:0] limit
);

  // ==========================================================
  // style table and reachable top index
  always_comb begin
    unique case ({sel_hi, sel_lo}) // [RQ1]
      2'b11: mode = hbad_pkg::HBAD_MUX3;
      2'b10: mode = hbad_pkg::HBAD_MUX2;
      2'b00: mode = hbad_pkg::HBAD_STROBE;
      2'b01: mode = hbad_pkg::HBAD_RDWR;
    endcase
    three_straps = (mode == hbad_pkg::HBAD_MUX3); // [RQ6]
    // both-high style with the lead low is refused outright
    illegal = three_straps & ~compat; // [RQ2]
    if (three_straps) begin
      limit = hbad_pkg::HBAD_LIM_MUX3; // [RQ2]
    end else if (compat) begin
      limit = hbad_pkg::HBAD_LIM_FULL; // [RQ3] [RQ4]
    end else begin
      limit = hbad_pkg::HBAD_LIM_COMPAT; // [RQ3] [RQ4]
    end
  end

endmodule

// file: hbad_axil_slv.sv
// Purpose: AXI4-Lite slave front end for the decode block's registers
// Assumes: register file answers combinationally on the carrier
// Notes: one write and one read in flight; readies drop while clk_en is low
`timescale 1ns/1ps
module hbad_axil_slv #(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // write channels
  input wire logic [ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // read channels
  input wire logic [ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // register file side
  hbad_reg_if.bus rif
);

  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  // ==========================================================
  // handshakes; address and data may arrive in either order
  assign s_axil_awready = clk_en & ~aw_q & ~b_q;
  assign s_axil_wready = clk_en & ~w_q & ~b_q;
  assign s_axil_arready = clk_en & ~r_q;
  assign s_axil_bvalid = b_q;
  assign s_axil_bresp = bresp_q;
  assign s_axil_rvalid = r_q;
  assign s_axil_rdata = rdata_q;
  assign s_axil_rresp = rresp_q;
  assign rif.wr_en = aw_q & w_q & ~b_q;
  assign rif.waddr = awaddr_q;
  assign rif.wdata = wdata_q;
  assign rif.wstrb = wstrb_q;
  assign rif.raddr = s_axil_araddr;

  // next state of both channel pairs
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axil_awvalid && s_axil_awready) begin
      aw_d = 1'b1;
      awaddr_d = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      w_d = 1'b1;
      wdata_d = s_axil_wdata;
      wstrb_d = s_axil_wstrb;
    end
    if (rif.wr_en) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = rif.wr_ok ? hbad_pkg::HBAD_RESP_OKAY : hbad_pkg::HBAD_RESP_SLVERR;
    end else if (b_q && s_axil_bready) begin
      b_d = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready) begin
      r_d = 1'b1;
      rdata_d = rif.rd_data;
      rresp_d = rif.rd_ok ? hbad_pkg::HBAD_RESP_OKAY : hbad_pkg::HBAD_RESP_SLVERR;
    end else if (r_q && s_axil_rready) begin
      r_d = 1'b0;
    end
  end

  // registers, frozen while clk_en is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bresp_q <= hbad_pkg::HBAD_RESP_OKAY;
      rdata_q <= 32'h0;
      rresp_q <= hbad_pkg::HBAD_RESP_OKAY;
    end else if (clk_en) begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule

// file: hbad_host_model.sv
// Purpose: host processor model on the 8-bit host port
// Assumes: pins change by non-blocking assignment just after a rising edge
// Notes: released shared lines show the inverse of the last host value
`timescale 1ns/1ps
module hbad_host_model (
  // clock and style
  input wire logic ref_clk,
  input wire logic mux,
  input wire logic rdwr,
  // host pins
  output logic [7:0] dedicated_addr_in,
  output logic [7:0] shared_addr_data_in,
  input wire logic [7:0] shared_addr_data_out,
  input wire logic shared_addr_data_oe_n,
  output logic host_sel_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic host_ale
);
  logic [7:0] hv = 8'h00;
  logic hdrv = 1'b0;
  // ==========================================================
  // wire level: device wins when enabled, else host or stale inverse
  assign shared_addr_data_in = !shared_addr_data_oe_n ? shared_addr_data_out : (hdrv ? hv : ~hv);
  initial begin
    dedicated_addr_in = 8'h00;
    {host_sel_n, host_rd_n, host_wr_n} = 3'h7;
    host_ale = 1'b0;
  end
  // ==========================================================
  // one cycle: address phase, strobes held three edges, then release
  task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] rd, output logic drove);
    @(posedge ref_clk);
    dedicated_addr_in <= mux ? ~a : a; // decoy value on mux styles
    hv <= a;
    hdrv <= mux;
    host_ale <= mux;
    @(posedge ref_clk);
    host_ale <= 1'b0;
    hv <= d;
    hdrv <= wr;
    host_sel_n <= 1'b0;
    host_rd_n <= rdwr ? !wr : wr;
    host_wr_n <= rdwr | !wr;
    repeat (2) @(posedge ref_clk);
    #1;
    rd = shared_addr_data_out;
    drove = !shared_addr_data_oe_n;
    @(posedge ref_clk);
    {host_sel_n, host_rd_n, host_wr_n} <= 3'h7;
    hdrv <= 1'b0;
    dedicated_addr_in <= ~a; // stale address is not left on the pins
  endtask
endmodule

// file: hbad_top_bench.sv
// Purpose: self-checking bench for the host port address decode
// Assumes: straps fixed at 101, registers reached over AXI4-Lite
// Notes: expected hits and misses are counted by the bench itself
`timescale 1ns/1ps
module hbad_top_bench;
  logic ref_clk, rst_n, sel_hi, sel_lo, compat, s_top, s_mid, s_low, drv;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic oe_n, sel_n, rd_n, wr_n, ale;
  logic [7:0] awaddr, araddr, ded, sh_in, sh_out, rd, top, base, d;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  int compares = 0, miscompares = 0, cycles = 0, n_hit = 0, n_miss = 0;
  // ==========================================================
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end
  hbad_top i_hbad_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .bus_type_sel_hi(sel_hi), .bus_type_sel_lo(sel_lo),
    .compat_mode_lead(compat), .segment_strap_top(s_top), .segment_strap_mid(s_mid), .segment_strap_low(s_low),
    .dedicated_addr_in(ded), .shared_addr_data_in(sh_in), .shared_addr_data_out(sh_out),
    .shared_addr_data_oe_n(oe_n), .host_sel_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_ale(ale),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
    .s_axil_rready(rready));
  hbad_host_model i_hbad_host_model (
    .ref_clk(ref_clk), .mux(sel_hi), .rdwr(sel_lo & ~sel_hi), .dedicated_addr_in(ded),
    .shared_addr_data_in(sh_in), .shared_addr_data_out(sh_out), .shared_addr_data_oe_n(oe_n),
    .host_sel_n(sel_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_ale(ale));
  // ==========================================================
  // compare, bus tasks and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // readies sampled at the falling edge so the release lands cleanly
  task automatic axw(input logic [7:0] a, input logic [31:0] dw, output logic [1:0] br);
    logic pa, pw, pb;
    {pa, pw, pb} = 3'h7;
    @(posedge ref_clk);
    {awaddr, wdata} <= {a, dw};
    {awvalid, wvalid, bready} <= 3'h7;
    while (pb) begin
      @(negedge ref_clk);
      if (pa && awready) pa = 1'b0;
      if (pw && wready) pw = 1'b0;
      if (!pa && !pw && bvalid) {pb, br} = {1'b0, bresp};
      @(posedge ref_clk);
      {awvalid, wvalid, bready} <= {pa, pw, pb};
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] rv, output logic [1:0] rr);
    logic pa, pr;
    {pa, pr} = 2'h3;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (pr) begin
      @(negedge ref_clk);
      if (pa && arready) pa = 1'b0;
      if (!pa && rvalid) begin
        pr = 1'b0;
        {rv, rr} = {rdata, rresp};
      end
      @(posedge ref_clk);
      {arvalid, rready} <= {pa, pr};
    end
  endtask
  task automatic hop(input logic wr, input logic [7:0] a, input logic [7:0] dh, input logic hit);
    i_hbad_host_model.cyc(wr, a, dh, rd, drv);
    if (hit) n_hit++;
    else n_miss++;
    chk(drv, hit && !wr);
    if (hit && !wr) chk(rd, dh);
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // every style with lead high then low, straps fixed at 101
  initial begin
    {rst_n, sel_hi, sel_lo, s_mid, awvalid, wvalid, bready, arvalid, rready} = '0;
    {compat, s_top, s_low} = '1;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int c = 1; c >= 0; c--) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge ref_clk);
        compat <= c[0];
        {sel_hi, sel_lo} <= {m < 2, (m == 0) || (m == 3)};
        top = (m == 0) ? 8'h1f : (c ? 8'h3f : 8'h24);
        base = (m == 0) ? 8'ha0 : 8'h80;
        d = {3'h5, c[0], 2'h0, m[1:0]};
        axr(hbad_pkg::HBAD_OFF_STATUS, v, r);
        chk(v[3:0], {c[0], (m == 0) && !c, m[1:0]});
        chk(r, hbad_pkg::HBAD_RESP_OKAY);
        hop(1'b1, base | top, d, (m != 0) || c);
        hop(1'b1, ((m == 0) ? 8'h80 : 8'h40) | top, ~d, 1'b0);
        hop(1'b0, base | top, d, (m != 0) || c);
        hop(1'b0, base + top + 8'h01, d, 1'b0);
        $display("test style %0d compat %0d done", m, c);
      end
    end
    axw(hbad_pkg::HBAD_OFF_CTRL, 32'h0, r);
    chk(r, hbad_pkg::HBAD_RESP_OKAY);
    hop(1'b0, 8'h80, 8'h00, 1'b0);
    axr(hbad_pkg::HBAD_OFF_HIT_CNT, v, r);
    chk(v, n_hit);
    axr(hbad_pkg::HBAD_OFF_MISS_CNT, v, r);
    chk(v, n_miss);
    // index 24 last took data in the read/write-line style with the lead low
    axw(hbad_pkg::HBAD_OFF_WIN_ADDR, 32'h24, r);
    axr(hbad_pkg::HBAD_OFF_WIN_DATA, v, r);
    chk(v, 32'ha3);
    axw(hbad_pkg::HBAD_OFF_CTRL, 32'h2, r);
    axr(hbad_pkg::HBAD_OFF_MISS_CNT, v, r);
    chk(v, 32'h0);
    axr(8'h40, v, r);
    chk(r, hbad_pkg::HBAD_RESP_SLVERR);
    $display("test counts done");
    close_out();
  end
endmodule
